// file: pkg/isr_params.svh
// offsets, field positions, reset values and widths of the status block
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
`define ISR_MASK_W        15
`define ISR_MASK_ALL      15'h7fff
`define ISR_A_OPER_EVT    8'h00
`define ISR_A_OPER_COND   8'h01
`define ISR_A_OPER_EN     8'h02
`define ISR_A_OPER_PTR    8'h03
`define ISR_A_OPER_NTR    8'h04
`define ISR_A_REG_EVT     8'h05
`define ISR_A_REG_COND    8'h06
`define ISR_A_REG_EN      8'h07
`define ISR_A_REG_PTR     8'h08
`define ISR_A_REG_NTR     8'h09
`define ISR_A_QUES_EN     8'h0a
`define ISR_A_QUES_PTR    8'h0b
`define ISR_A_QUES_NTR    8'h0c
`define ISR_A_ESR         8'h10
`define ISR_A_ESE         8'h11
`define ISR_A_SRE         8'h12
`define ISR_A_PRE         8'h13
`define ISR_A_STB         8'h14
`define ISR_A_IST         8'h15
`define ISR_A_PSC         8'h16
`define ISR_A_CMD         8'h17
`define ISR_A_STAT        8'h18
`define ISR_CMD_PRESET    0
`define ISR_CMD_CLS       1
`define ISR_CMD_OPC       2
`define ISR_CMD_WAI       3
`define ISR_STB_ERR       2
`define ISR_STB_QUES      3
`define ISR_STB_MAV       4
`define ISR_STB_ESB       5
`define ISR_STB_MSS       6
`define ISR_STB_OPER      7
`define ISR_ESR_OPC       0
`endif

// file: pkg/isr_pkg.sv
// types shared by the status block
`default_nettype none
package isr_pkg;
  typedef logic [14:0] isr_mask_t;
  typedef struct packed {
    isr_mask_t cond_q;
    isr_mask_t evt_q;
    isr_mask_t en_q;
    isr_mask_t ptr_q;
    isr_mask_t ntr_q;
  } isr_grp_t;
  typedef enum logic [1:0] {
    ISR_IDLE    = 2'b00,
    ISR_OPC_ARM = 2'b01,
    ISR_WAIT    = 2'b10
  } isr_state_t;
endpackage
`default_nettype wire

// file: pkg/isr_grp_if.sv
// interface carrying one event group's controls and results
`timescale 1ns/1ps
`default_nettype none
interface isr_grp_if;
  import isr_pkg::*;
  logic      wr_en;
  logic      wr_ptr;
  logic      wr_ntr;
  logic      rd_evt;
  logic      preset;
  logic      clear;
  isr_mask_t wdata;
  isr_mask_t cond;
  isr_grp_t  st;
  logic      summary;
  modport grp (input wr_en, wr_ptr, wr_ntr, rd_evt, preset, clear, wdata, cond,
               output st, summary);
  modport ctl (output wr_en, wr_ptr, wr_ntr, rd_evt, preset, clear, wdata, cond,
               input st, summary);
endinterface
`default_nettype wire

// file: logic/isr_group.sv
// one event group: condition, transition filters, sticky event, enable
`timescale 1ns/1ps
`default_nettype none
`include "isr_params.svh"
module isr_group #(
  parameter logic [14:0] EN_PRESET = 15'h0000
) (
  input wire logic clk,
  input wire logic rstn,
  isr_grp_if.grp   g
);
  import isr_pkg::*;
  isr_grp_t  s_q, s_d;
  isr_mask_t rise, fall;

  // edge detect against the previous condition
  always_comb begin
    rise = g.cond & ~s_q.cond_q;
    fall = ~g.cond & s_q.cond_q;
    s_d = s_q;
    s_d.cond_q = g.cond;
    if (g.rd_evt || g.clear) begin
      s_d.evt_q = '0;
    end
    // new transitions win over a read-clear in the same cycle
    s_d.evt_q = s_d.evt_q | (rise & s_q.ptr_q) | (fall & s_q.ntr_q);
    if (g.wr_en) s_d.en_q = g.wdata;
    if (g.wr_ptr) s_d.ptr_q = g.wdata;
    if (g.wr_ntr) s_d.ntr_q = g.wdata;
    if (g.preset) begin
      s_d.en_q  = EN_PRESET;
      s_d.ptr_q = `ISR_MASK_ALL;
      s_d.ntr_q = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= {15'h0000, 15'h0000, 15'h0000, 15'h7fff, 15'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign g.st      = s_q;
  assign g.summary = |(s_q.evt_q & s_q.en_q);
endmodule // isr_group
`default_nettype wire

// file: logic/isr_status.sv
// status reporting core: groups, standard event, status byte, poll logic
`timescale 1ns/1ps
`default_nettype none
`include "isr_params.svh"

module isr_status (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [7:0]             addr,
  input  wire logic [15:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [15:0]            rdata,
  input  wire isr_pkg::isr_mask_t     oper_cond_pin,
  input  wire isr_pkg::isr_mask_t     reg_cond_pin,
  input  wire isr_pkg::isr_mask_t     ques_evt_pin,
  input  wire logic [7:0]             std_event_set,
  input  wire logic                   err_queue_nonempty,
  input  wire logic                   msg_available,
  input  wire logic                   ops_pending,
  output logic                        err_queue_clear,
  output logic                        cmd_stall,
  output logic                        srq,
  output logic                        ist,
  output logic                        psc_flag
);
  import isr_pkg::*;

  // ----------------------------------------
  // state and pin synchronisers
  // ----------------------------------------
  typedef struct packed {
    logic [1:0][14:0] oc_s;
    logic [1:0][14:0] rc_s;
    logic [1:0][14:0] qe_s;
    logic [1:0][7:0]  se_s;
    logic [1:0]       eq_s;
    logic [1:0]       ma_s;
    logic [1:0]       op_s;
    isr_mask_t        ques_evt_q;
    isr_mask_t        ques_en_q;
    isr_mask_t        ques_ptr_q;
    isr_mask_t        ques_ntr_q;
    logic [7:0]       esr_q;
    logic [7:0]       ese_q;
    logic [7:0]       sre_q;
    logic [15:0]      pre_q;
    logic             psc_q;
    logic             por_q;
    isr_state_t       st_q;
    logic [15:0]      rdata_q;
    logic             eqclr_q;
    logic             stall_q;
    logic             srq_q;
    logic             ist_q;
  } isr_core_t;

  isr_core_t q, d;
  isr_grp_if oper_if ();
  isr_grp_if reg_if ();
  logic [7:0] stb;
  logic       mss, ist_now, wr_cmd;

  // status byte from the synchronised and latched sources
  function automatic logic [7:0] make_stb(input logic err, input logic ques,
                                          input logic mav, input logic esb,
                                          input logic oper, input logic [7:0] sre);
    logic [7:0] b;
    b = 8'h00;
    b[`ISR_STB_ERR]  = err;
    b[`ISR_STB_QUES] = ques;
    b[`ISR_STB_MAV]  = mav;
    b[`ISR_STB_ESB]  = esb;
    b[`ISR_STB_OPER] = oper;
    b[`ISR_STB_MSS]  = |(b & sre & 8'hbf);
    return b;
  endfunction

  // ----------------------------------------
  // event groups
  // ----------------------------------------
  // the regulating sub-structure is device dependent, hence all-ones preset enable
  isr_group #(.EN_PRESET(15'h0000)) u_oper (.clk(clk), .rstn(rstn), .g(oper_if.grp));
  isr_group #(.EN_PRESET(`ISR_MASK_ALL)) u_reg (.clk(clk), .rstn(rstn), .g(reg_if.grp));

  assign wr_cmd = wr && (addr == `ISR_A_CMD) && (q.st_q != ISR_WAIT);

  // group controls decoded from the register port
  always_comb begin
    oper_if.wdata  = wdata[14:0];
    reg_if.wdata   = wdata[14:0];
    oper_if.cond   = q.oc_s[1];
    reg_if.cond    = q.rc_s[1];
    oper_if.wr_en  = wr && addr == `ISR_A_OPER_EN;
    oper_if.wr_ptr = wr && addr == `ISR_A_OPER_PTR;
    oper_if.wr_ntr = wr && addr == `ISR_A_OPER_NTR;
    oper_if.rd_evt = rd && addr == `ISR_A_OPER_EVT;
    reg_if.wr_en   = wr && addr == `ISR_A_REG_EN;
    reg_if.wr_ptr  = wr && addr == `ISR_A_REG_PTR;
    reg_if.wr_ntr  = wr && addr == `ISR_A_REG_NTR;
    reg_if.rd_evt  = rd && addr == `ISR_A_REG_EVT;
    oper_if.preset = wr_cmd && wdata[`ISR_CMD_PRESET];
    reg_if.preset  = wr_cmd && wdata[`ISR_CMD_PRESET];
    oper_if.clear  = wr_cmd && wdata[`ISR_CMD_CLS];
    reg_if.clear   = wr_cmd && wdata[`ISR_CMD_CLS];
  end

  // ----------------------------------------
  // core next state
  // ----------------------------------------
  // the operation summary is fed back one cycle later through the group's register
  always_comb begin
    d = q;
    d.oc_s = {q.oc_s[0], oper_cond_pin};
    d.rc_s = {q.rc_s[0], reg_cond_pin};
    d.qe_s = {q.qe_s[0], ques_evt_pin};
    d.se_s = {q.se_s[0], std_event_set};
    d.eq_s = {q.eq_s[0], err_queue_nonempty};
    d.ma_s = {q.ma_s[0], msg_available};
    d.op_s = {q.op_s[0], ops_pending};
    stb = make_stb(q.eq_s[1], |(q.ques_evt_q & q.ques_en_q), q.ma_s[1],
                   |(q.esr_q & q.ese_q), oper_if.summary, q.sre_q);
    mss = stb[`ISR_STB_MSS];
    ist_now = |({8'h00, stb} & q.pre_q);
    d.eqclr_q = 1'b0;
    d.rdata_q = 16'h0000;
    // power-on clear: caught on the first cycle after reset release
    d.por_q = 1'b0;
    if (q.por_q && q.psc_q) begin
      d.sre_q = 8'h00;
      d.ese_q = 8'h00;
      d.pre_q = 16'h0000;
      d.eqclr_q = 1'b1;
    end
    // register reads, data valid next cycle only
    if (rd) begin
      case (addr)
        `ISR_A_OPER_EVT:  d.rdata_q = {1'b0, oper_if.st.evt_q};
        `ISR_A_OPER_COND: d.rdata_q = {1'b0, oper_if.st.cond_q};
        `ISR_A_OPER_EN:   d.rdata_q = {1'b0, oper_if.st.en_q};
        `ISR_A_OPER_PTR:  d.rdata_q = {1'b0, oper_if.st.ptr_q};
        `ISR_A_OPER_NTR:  d.rdata_q = {1'b0, oper_if.st.ntr_q};
        `ISR_A_REG_EVT:   d.rdata_q = {1'b0, reg_if.st.evt_q};
        `ISR_A_REG_COND:  d.rdata_q = {1'b0, reg_if.st.cond_q};
        `ISR_A_REG_EN:    d.rdata_q = {1'b0, reg_if.st.en_q};
        `ISR_A_REG_PTR:   d.rdata_q = {1'b0, reg_if.st.ptr_q};
        `ISR_A_REG_NTR:   d.rdata_q = {1'b0, reg_if.st.ntr_q};
        `ISR_A_QUES_EN:   d.rdata_q = {1'b0, q.ques_en_q};
        `ISR_A_QUES_PTR:  d.rdata_q = {1'b0, q.ques_ptr_q};
        `ISR_A_QUES_NTR:  d.rdata_q = {1'b0, q.ques_ntr_q};
        `ISR_A_ESR: begin
          d.rdata_q = {8'h00, q.esr_q};
          d.esr_q = 8'h00;
        end
        `ISR_A_ESE:       d.rdata_q = {8'h00, q.ese_q};
        `ISR_A_SRE:       d.rdata_q = {8'h00, q.sre_q};
        `ISR_A_PRE:       d.rdata_q = q.pre_q;
        `ISR_A_STB:       d.rdata_q = {8'h00, stb};
        `ISR_A_IST:       d.rdata_q = {15'h0000, ist_now};
        `ISR_A_PSC:       d.rdata_q = {15'h0000, q.psc_q};
        `ISR_A_STAT:      d.rdata_q = {14'h0000, q.st_q};
        default:          d.rdata_q = 16'h0000;
      endcase
    end
    // register writes; preset never touches sre, pre or psc
    if (wr) begin
      case (addr)
        `ISR_A_QUES_EN:  d.ques_en_q  = wdata[14:0];
        `ISR_A_QUES_PTR: d.ques_ptr_q = wdata[14:0];
        `ISR_A_QUES_NTR: d.ques_ntr_q = wdata[14:0];
        `ISR_A_ESE:      d.ese_q = wdata[7:0];
        `ISR_A_SRE:      d.sre_q = wdata[7:0];
        `ISR_A_PRE:      d.pre_q = wdata;
        `ISR_A_PSC:      d.psc_q = wdata[0];
        default:         d.psc_q = q.psc_q;
      endcase
    end
    if (wr_cmd && wdata[`ISR_CMD_PRESET]) begin
      d.ques_en_q  = 15'h0000;
      d.ques_ptr_q = `ISR_MASK_ALL;
      d.ques_ntr_q = 15'h0000;
    end
    if (wr_cmd && wdata[`ISR_CMD_CLS]) begin
      d.esr_q = 8'h00;
      d.ques_evt_q = 15'h0000;
      d.eqclr_q = 1'b1;
    end
    // sticky sets win over any clear in the same cycle
    d.ques_evt_q = d.ques_evt_q | q.qe_s[1];
    d.esr_q = d.esr_q | (q.se_s[1] & 8'hfc);
    // completion sequencer
    case (q.st_q)
      ISR_IDLE: begin
        if (wr_cmd && wdata[`ISR_CMD_WAI]) d.st_q = ISR_WAIT;
        else if (wr_cmd && wdata[`ISR_CMD_OPC]) d.st_q = ISR_OPC_ARM;
      end
      ISR_OPC_ARM: begin
        if (!q.op_s[1]) begin
          d.esr_q[`ISR_ESR_OPC] = 1'b1;
          d.st_q = ISR_IDLE;
        end else if (wr_cmd && wdata[`ISR_CMD_WAI]) d.st_q = ISR_WAIT;
      end
      ISR_WAIT: begin
        if (!q.op_s[1]) d.st_q = ISR_IDLE;
      end
      default: d.st_q = ISR_IDLE;
    endcase
    d.stall_q = (d.st_q == ISR_WAIT);
    d.srq_q = mss;
    d.ist_q = ist_now;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.ques_ptr_q <= `ISR_MASK_ALL;
      q.psc_q <= 1'b1;
      q.por_q <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign rdata           = q.rdata_q;
  assign err_queue_clear = q.eqclr_q;
  assign cmd_stall       = q.stall_q;
  assign srq             = q.srq_q;
  assign ist             = q.ist_q;
  assign psc_flag        = q.psc_q;
endmodule // isr_status
`default_nettype wire

// file: sim/isr_status_props.sv
// port assertions for the status block
`timescale 1ns/1ps
`default_nettype none
`include "isr_params.svh"
module isr_status_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        ops_pending,
  input wire logic        err_queue_clear,
  input wire logic        cmd_stall,
  input wire logic        srq,
  input wire logic        ist,
  input wire logic        psc_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------
  // port relations
  // ----------------
  // read data only stands in the cycle after a read strobe
  rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data without a read");
  mask_w_a: assert property ($past(rd) && $past(addr) <= `ISR_A_QUES_NTR |-> !rdata[15])
    else $error("mask wider than 15 bits");
  sre_zero_a: assert property (wr && addr == `ISR_A_SRE && wdata[7:0] == 8'h00 ##1 (!wr) [*2] |-> !srq)
    else $error("service request with zero enable");
  psc_hold_a: assert property (!(wr && addr == `ISR_A_PSC) |=> $stable(psc_flag))
    else $error("power-on flag moved without write");
  psc_wr_a: assert property (wr && addr == `ISR_A_PSC |=> psc_flag == $past(wdata[0]))
    else $error("power-on flag write lost");
  // a clear while waiting is refused, so only free cycles count
  cls_clr_a: assert property (wr && addr == `ISR_A_CMD && wdata[1] && !cmd_stall |-> ##[1:3] err_queue_clear)
    else $error("clear-status left the error queue");
  wai_hold_a: assert property (ops_pending [*4] ##0 cmd_stall |=> cmd_stall)
    else $error("stall dropped while pending");
  wai_end_a: assert property ((!ops_pending && !wr) [*8] |-> !cmd_stall)
    else $error("stall held with nothing pending");
  stb_mss_a: assert property (rd && addr == `ISR_A_STB ##1 $stable(srq) |-> rdata[6] == srq)
    else $error("status byte bit 6 differs from summary");
  ist_rd_a: assert property (rd && addr == `ISR_A_IST ##1 $stable(ist) |-> rdata == 16'(ist))
    else $error("individual status read differs");
endmodule // isr_status_props
bind isr_status isr_status_props isr_status_props_i (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ops_pending(ops_pending),
  .err_queue_clear(err_queue_clear), .cmd_stall(cmd_stall), .srq(srq), .ist(ist),
  .psc_flag(psc_flag));
`default_nettype wire

// file: sim/isr_ctl_model.sv
// far-side model: pending operations and the error queue
`timescale 1ns/1ps
`default_nettype none
module isr_ctl_model #(
  parameter int BUSY = 20
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic start,
  input  wire logic err_push,
  input  wire logic err_queue_clear,
  output logic      ops_pending,
  output logic      err_queue_nonempty
);
  int cnt_q;
  // ----------------
  // behaviour
  // ----------------
  // pending stays up a fixed span after start; the queue empties only on the clear pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 0;
      err_queue_nonempty <= 1'b0;
    end else begin
      cnt_q <= start ? BUSY : (cnt_q > 0 ? cnt_q - 1 : 0);
      if (err_queue_clear)
        err_queue_nonempty <= 1'b0;
      else if (err_push)
        err_queue_nonempty <= 1'b1;
    end
  end
  assign ops_pending = cnt_q > 0;
endmodule // isr_ctl_model
`default_nettype wire

// file: sim/tb_instrument_status_reporting.sv
// testbench for the status block
`timescale 1ns/1ps
`default_nettype none
`include "isr_params.svh"
module tb_instrument_status_reporting;
  import isr_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, start = 0, err_push = 0, msg_available = 0;
  int n_clr = 0;
  logic [7:0] addr = 8'h00, std_event_set = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  isr_mask_t oper_cond_pin = 15'h0000, reg_cond_pin = 15'h0000, ques_evt_pin = 15'h0000;
  logic err_queue_nonempty, ops_pending, err_queue_clear, cmd_stall, srq, ist, psc_flag;
  int n_mismatch = 0, tests_run = 0;
  always #50 clk = ~clk;
  // counts clear pulses so a scenario can demand exactly one, with a single driver
  always @(posedge clk) if (err_queue_clear === 1'b1) n_clr <= n_clr + 1;
  isr_status isr_status_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .oper_cond_pin(oper_cond_pin), .reg_cond_pin(reg_cond_pin),
    .ques_evt_pin(ques_evt_pin), .std_event_set(std_event_set),
    .err_queue_nonempty(err_queue_nonempty), .msg_available(msg_available),
    .ops_pending(ops_pending), .err_queue_clear(err_queue_clear), .cmd_stall(cmd_stall),
    .srq(srq), .ist(ist), .psc_flag(psc_flag));
  isr_ctl_model isr_ctl_model_i (.clk(clk), .rstn(rstn), .start(start), .err_push(err_push),
    .err_queue_clear(err_queue_clear), .ops_pending(ops_pending),
    .err_queue_nonempty(err_queue_nonempty));
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data is taken in the single cycle after the strobe
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic summarize;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset;
    rreg(`ISR_A_OPER_EN, 16'h0000);
    rreg(`ISR_A_OPER_PTR, 16'h7fff);
    rreg(`ISR_A_SRE, 16'h0000);
    rreg(`ISR_A_PSC, 16'h0001);
    rreg(8'h3f, 16'h0000);
    chk(16'(n_clr), 16'h0001);
    // drop the power-on flag so that a later preset can be seen to leave it alone
    wreg(`ISR_A_PSC, 16'h0000);
    rreg(`ISR_A_PSC, 16'h0000);
    chk(16'(psc_flag), 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_events;
    wreg(`ISR_A_OPER_EN, 16'hffff);
    rreg(`ISR_A_OPER_EN, 16'h7fff);
    wreg(`ISR_A_REG_PTR, 16'h0000);
    wreg(`ISR_A_REG_NTR, 16'h0004);
    oper_cond_pin <= 15'h0001;
    reg_cond_pin <= 15'h0004;
    idle(6);
    rreg(`ISR_A_REG_COND, 16'h0004);
    rreg(`ISR_A_OPER_COND, 16'h0001);
    rreg(`ISR_A_STB, 16'h0080);
    rreg(`ISR_A_REG_EVT, 16'h0000);
    rreg(`ISR_A_OPER_EVT, 16'h0001);
    rreg(`ISR_A_OPER_EVT, 16'h0000);
    reg_cond_pin <= 15'h0000;
    idle(6);
    rreg(`ISR_A_REG_EVT, 16'h0004);
    rreg(`ISR_A_STB, 16'h0000);
    $display("t_events done");
  endtask
  task automatic t_preset;
    wreg(`ISR_A_SRE, 16'h0080);
    wreg(`ISR_A_QUES_EN, 16'h0001);
    wreg(`ISR_A_OPER_NTR, 16'h0001);
    wreg(`ISR_A_OPER_PTR, 16'h0000);
    ques_evt_pin <= 15'h0001;
    oper_cond_pin <= 15'h0000;
    idle(6);
    ques_evt_pin <= 15'h0000;
    rreg(`ISR_A_STB, 16'h00c8);
    chk(16'(srq), 16'h0001);
    rreg(`ISR_A_STB, 16'h00c8);
    wreg(`ISR_A_CMD, 16'h0001);
    idle(4);
    rreg(`ISR_A_OPER_EN, 16'h0000);
    rreg(`ISR_A_OPER_NTR, 16'h0000);
    rreg(`ISR_A_QUES_EN, 16'h0000);
    rreg(`ISR_A_REG_EN, 16'h7fff);
    rreg(`ISR_A_REG_NTR, 16'h0000);
    rreg(`ISR_A_REG_PTR, 16'h7fff);
    rreg(`ISR_A_OPER_PTR, 16'h7fff);
    rreg(`ISR_A_SRE, 16'h0080);
    rreg(`ISR_A_PSC, 16'h0000);
    chk(16'(psc_flag), 16'h0000);
    rreg(`ISR_A_OPER_EVT, 16'h0001);
    $display("t_preset done");
  endtask
  task automatic t_std;
    int c0;
    wreg(`ISR_A_ESE, 16'h0010);
    wreg(`ISR_A_SRE, 16'h0020);
    wreg(`ISR_A_PRE, 16'h0020);
    std_event_set <= 8'h10;
    err_push <= 1'b1;
    msg_available <= 1'b1;
    idle(2);
    std_event_set <= 8'h00;
    err_push <= 1'b0;
    idle(6);
    rreg(`ISR_A_STB, 16'h0074);
    chk(16'(ist), 16'h0001);
    rreg(`ISR_A_IST, 16'h0001);
    wreg(`ISR_A_SRE, 16'h0000);
    idle(3);
    chk(16'(srq), 16'h0000);
    c0 = n_clr;
    wreg(`ISR_A_CMD, 16'h0002);
    idle(6);
    chk(16'(n_clr - c0), 16'h0001);
    rreg(`ISR_A_STB, 16'h0010);
    rreg(`ISR_A_OPER_EVT, 16'h0000);
    $display("t_std done");
  endtask
  task automatic t_wai;
    int k;
    wreg(`ISR_A_OPER_EN, 16'h0003);
    start <= 1'b1;
    idle(1);
    start <= 1'b0;
    idle(3);
    wreg(`ISR_A_CMD, 16'h0008);
    idle(2);
    chk(16'(cmd_stall), 16'h0001);
    rreg(`ISR_A_STAT, 16'h0002);
    // a preset issued while stalled is refused, so the enable must survive
    wreg(`ISR_A_CMD, 16'h0001);
    k = 0;
    while (cmd_stall === 1'b1 && k < 100) begin
      idle(1);
      k++;
    end
    chk(16'(ops_pending), 16'h0000);
    rreg(`ISR_A_OPER_EN, 16'h0003);
    start <= 1'b1;
    idle(1);
    start <= 1'b0;
    wreg(`ISR_A_CMD, 16'h0004);
    idle(3);
    rreg(`ISR_A_ESR, 16'h0000);
    idle(30);
    rreg(`ISR_A_ESR, 16'h0001);
    rreg(`ISR_A_ESR, 16'h0000);
    $display("t_wai done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_events;
    t_preset;
    t_std;
    t_wai;
    summarize;
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    summarize;
  end
endmodule // tb_instrument_status_reporting
`default_nettype wire
